// ==== design/irm_master.sv ====
// Contract
// (R1) write address byte is address<<1 with zero
// (R2) read address byte is address<<1 with one
// (R3) read address only after write address, register
// (R4) repeated start, not stop, before read address
// (R5) repeated start request self-clears after use
// (R6) final write byte acknowledged ends with stop
// (R7) stop by leaving master mode, engine off
// (R8) first read byte: receive direction, ack enabled
// (R9) final read byte answered NAK, others ACK
// (R10) first received byte started by its own command
// (R11) each read request clocks exactly one byte
// (R12) master mode left before final byte taken
// (R13) engine disabled after final byte taken
// (R14) power-down line low until released
// (R15) engine re-enabled for every transaction
// (R16) target returns least significant byte first
// (R17) every sent byte checked for acknowledge
`timescale 1ns/10ps
`default_nettype none

module irm_master
   import irm_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYC                 // cycles per quarter bit
) (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // user command port
   input  wire logic       cmd_valid_i,                // command offered
   output logic            cmd_ready_o,                // sequencer idle
   input  wire irm_op_t    cmd_op_i,                   // what to do
   input  wire logic [6:0] tgt_addr_i,                 // 7-bit target address
   input  wire logic [7:0] cmd_data_i,                 // byte to send
   input  wire logic       final_byte_flag_i,          // last byte of transaction
   output logic            rsp_valid_o,                // one-cycle completion pulse
   output logic [7:0]      rsp_data_o,                 // byte received
   output logic            rsp_nak_o,                  // target nak or refused command
   output logic            busy_o,                     // master mode held
   // power-down control
   input  wire logic       pd_release_i,               // lift the power-down line
   output logic            pd_n_o,                     // power-down line, low = down
   // open-drain bus pins
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_n_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o
);

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   typedef struct packed {
      irm_state_t  st;                                 // sequencer state
      logic [1:0]  q;                                  // quarter within a bit
      logic [3:0]  bitn;                               // bit index, 8 = ack slot
      logic [7:0]  sh;                                 // shift register
      logic        scl_low;                            // pulling scl
      logic        sda_low;                            // pulling sda
      logic        active;                             // master mode held
      logic        rd;                                 // current byte is received
      logic        fin;                                // current byte is final
      logic        addr_ph;                            // current byte is an address
      logic        dir_rd;                             // address phase was read
      logic        reg_sent;                           // register byte written
      logic        rx_ok;                              // read address acknowledged
      logic        nak;                                // answer status
      logic        rsp_v;                              // answer pulse
      logic [7:0]  out;                                // answer data
      logic        pd_n;                               // power-down line
   } irm_regs_t;

   localparam irm_regs_t RESET_STATE = '{st: ST_IDLE, pd_n: PD_N_RESET, default: '0};

   irm_regs_t r_reg;
   irm_regs_t r_next;
   logic      tick;                                    // quarter enable

   irm_tick #(.DIV(QUARTER)) u_tick (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .run_i   (r_reg.st != ST_IDLE),
      .tick_o  (tick)
   );

   // ---------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------
   always_comb begin
      r_next       = r_reg;
      r_next.rsp_v = 1'b0;
      if (pd_release_i) begin
         r_next.pd_n = 1'b1;                           // see (R14)
      end
      unique case (r_reg.st)
         ST_IDLE: begin
            if (cmd_valid_i) begin
               r_next.q    = Q_DRIVE;
               r_next.bitn = 4'h0;
               unique case (cmd_op_i)
                  OP_ADDR_WR: begin
                     // fresh transaction re-enables the engine
                     r_next.sh       = {tgt_addr_i, RW_WRITE};          // see (R1)
                     r_next.active   = 1'b1;                            // see (R15)
                     r_next.st       = r_reg.active ? ST_RSTART : ST_START;
                     r_next.rd       = 1'b0;
                     r_next.fin      = 1'b0;
                     r_next.addr_ph  = 1'b1;
                     r_next.dir_rd   = 1'b0;
                     r_next.reg_sent = 1'b0;
                     r_next.rx_ok    = 1'b0;
                  end
                  OP_WRITE: begin
                     if (r_reg.active && !r_reg.rx_ok) begin
                        r_next.sh      = cmd_data_i;
                        r_next.fin     = final_byte_flag_i;             // see (R6)
                        r_next.rd      = 1'b0;
                        r_next.addr_ph = 1'b0;
                        r_next.st      = ST_BIT;
                     end else begin
                        r_next.rsp_v = 1'b1;
                        r_next.nak   = 1'b1;
                     end
                  end
                  OP_RSTART_RD: begin
                     // refused unless a register byte is already on the target
                     if (r_reg.active && r_reg.reg_sent && !r_reg.rx_ok) begin   // see (R3)
                        r_next.sh      = {tgt_addr_i, RW_READ};         // see (R2)
                        r_next.rd      = 1'b0;
                        r_next.fin     = 1'b0;
                        r_next.addr_ph = 1'b1;
                        r_next.dir_rd  = 1'b1;
                        r_next.st      = ST_RSTART;                     // see (R4) (R5)
                     end else begin
                        r_next.rsp_v = 1'b1;
                        r_next.nak   = 1'b1;
                     end
                  end
                  OP_READ: begin
                     // one command clocks exactly one byte, never a spare one
                     if (r_reg.rx_ok) begin                             // see (R10) (R11)
                        r_next.rd      = 1'b1;                          // see (R8)
                        r_next.fin     = final_byte_flag_i;
                        r_next.addr_ph = 1'b0;
                        r_next.st      = ST_BIT;
                     end else begin
                        r_next.rsp_v = 1'b1;
                        r_next.nak   = 1'b1;
                     end
                  end
               endcase
            end
         end
         ST_START: begin
            // sda falls with scl high, then scl falls
            if (tick) begin
               if (r_reg.q == Q_DRIVE) begin
                  r_next.sda_low = 1'b1;
                  r_next.q       = Q_RISE;
               end else begin
                  r_next.scl_low = 1'b1;
                  r_next.st      = ST_BIT;
                  r_next.q       = Q_DRIVE;
               end
            end
         end
         ST_RSTART: begin
            // release sda, raise scl, pull sda low, pull scl low
            if (tick) begin
               r_next.q = r_reg.q + 2'h1;
               unique case (r_reg.q)
                  Q_DRIVE:  r_next.sda_low = 1'b0;
                  Q_RISE:   r_next.scl_low = 1'b0;
                  Q_SAMPLE: r_next.sda_low = 1'b1;
                  Q_FALL: begin
                     r_next.scl_low = 1'b1;
                     r_next.st      = ST_BIT;
                  end
               endcase
            end
         end
         ST_BIT: begin
            if (tick) begin
               unique case (r_reg.q)
                  Q_DRIVE: begin
                     if (r_reg.bitn == ACK_SLOT) begin
                        // ack every received byte but the final one
                        r_next.sda_low = r_reg.rd && !r_reg.fin;        // see (R9)
                     end else begin
                        r_next.sda_low = !r_reg.rd && !r_reg.sh[7];
                     end
                     r_next.q = Q_RISE;
                  end
                  Q_RISE: begin
                     r_next.scl_low = 1'b0;
                     r_next.q       = Q_SAMPLE;
                  end
                  Q_SAMPLE: begin
                     // a target holding scl low stretches the bit
                     if (scl_i) begin
                        if (r_reg.bitn == ACK_SLOT) begin
                           r_next.nak = !r_reg.rd && sda_i;             // see (R17)
                        end else if (r_reg.rd) begin
                           r_next.sh = {r_reg.sh[6:0], sda_i};
                        end
                        r_next.q = Q_FALL;
                     end
                  end
                  Q_FALL: begin
                     r_next.scl_low = 1'b1;
                     r_next.q       = Q_DRIVE;
                     if (r_reg.bitn == ACK_SLOT) begin
                        r_next.bitn    = 4'h0;
                        r_next.rsp_v   = 1'b1;
                        r_next.out     = r_reg.sh;
                        // sda stays put here: moving it as scl falls could look like a start or stop
                        r_next.reg_sent = r_reg.reg_sent || (!r_reg.rd && !r_reg.addr_ph);
                        r_next.rx_ok   = r_reg.rx_ok || (r_reg.addr_ph && r_reg.dir_rd && !r_next.nak);
                        // final byte or refusal ends in stop before the byte is handed over
                        if (r_next.nak || r_reg.fin) begin              // see (R6) (R12) (R17)
                           r_next.rsp_v = 1'b0;
                           r_next.st    = ST_STOP;
                        end else begin
                           r_next.st = ST_IDLE;
                        end
                     end else begin
                        r_next.bitn = r_reg.bitn + 4'h1;
                        if (!r_reg.rd) begin
                           r_next.sh = {r_reg.sh[6:0], 1'b0};
                        end
                     end
                  end
               endcase
            end
         end
         ST_STOP: begin
            // sda pulled while scl is low, scl rises, then sda rises: master mode is left
            if (tick) begin
               if (r_reg.q == Q_DRIVE) begin
                  r_next.sda_low = 1'b1;
                  r_next.q       = Q_RISE;
               end else if (r_reg.q == Q_RISE) begin
                  r_next.scl_low = 1'b0;
                  r_next.q       = Q_SAMPLE;
               end else begin
                  r_next.sda_low = 1'b0;                        // see (R7)
                  r_next.active  = 1'b0;                        // see (R7) (R13)
                  r_next.rx_ok   = 1'b0;
                  r_next.reg_sent = 1'b0;
                  r_next.rsp_v   = 1'b1;                        // see (R12)
                  r_next.st      = ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r_reg <= RESET_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------
   assign cmd_ready_o = (r_reg.st == ST_IDLE);
   assign rsp_valid_o = r_reg.rsp_v;
   assign rsp_data_o  = r_reg.out;                      // bytes arrive low first, see (R16)
   assign rsp_nak_o   = r_reg.nak;
   assign busy_o      = r_reg.active;
   assign pd_n_o      = r_reg.pd_n;
   assign scl_o       = 1'b0;
   assign sda_o       = 1'b0;
   assign scl_oe_n_o  = !r_reg.scl_low;
   assign sda_oe_n_o  = !r_reg.sda_low;

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   wire acc = cmd_valid_i && cmd_ready_o;
   wire ack_end = r_reg.st == ST_BIT && r_reg.bitn == ACK_SLOT && r_reg.q == Q_FALL && tick;

   a_wr_addr_byte: assert property ( // see (R1)
      acc && cmd_op_i == OP_ADDR_WR |=> r_reg.sh == {$past(tgt_addr_i), 1'b0})
      else $error("write address byte wrong");
   a_rd_addr_byte: assert property ( // see (R2)
      acc && cmd_op_i == OP_RSTART_RD && r_reg.reg_sent && !r_reg.rx_ok |=> r_reg.sh == {$past(tgt_addr_i), 1'b1})
      else $error("read address byte wrong");
   a_rd_needs_reg: assert property ( // see (R3)
      acc && cmd_op_i == OP_RSTART_RD && !r_reg.reg_sent |=> rsp_valid_o && rsp_nak_o && cmd_ready_o)
      else $error("read address accepted without register byte");
   a_rstart_no_stop: assert property ( // see (R4)
      acc && cmd_op_i == OP_RSTART_RD && r_reg.reg_sent && !r_reg.rx_ok |=> r_reg.st == ST_RSTART && busy_o)
      else $error("stop placed before read address");
   a_final_wr_stop: assert property ( // see (R6)
      ack_end && !r_reg.rd && r_reg.fin |=> r_reg.st == ST_STOP && !rsp_valid_o)
      else $error("final write not followed by stop");
   a_stop_leaves: assert property ( // see (R7)
      r_reg.st == ST_STOP && r_reg.q == Q_SAMPLE && tick |=> !busy_o && sda_oe_n_o && scl_oe_n_o && rsp_valid_o)
      else $error("stop did not leave master mode");
   a_rd_ack_level: assert property ( // see (R9)
      r_reg.st == ST_BIT && r_reg.rd && r_reg.bitn == ACK_SLOT && r_reg.q != Q_DRIVE |-> sda_oe_n_o == r_reg.fin)
      else $error("read ack level wrong");
   a_pd_held_low: assert property ( // see (R14)
      $rose(pd_n_o) |-> $past(pd_release_i))
      else $error("power-down released without request");
   a_nak_caught: assert property ( // see (R17)
      r_reg.st == ST_BIT && !r_reg.rd && r_reg.bitn == ACK_SLOT && r_reg.q == Q_SAMPLE && tick && scl_i && sda_i
      |=> rsp_nak_o ##1 1'b1)
      else $error("target nak not recorded");

   c_write_done: cover property (ack_end && !r_reg.rd && r_reg.fin);
   c_rstart:     cover property (r_reg.st == ST_RSTART && r_reg.dir_rd);
   c_read_last:  cover property (ack_end && r_reg.rd && r_reg.fin);
   c_nak:        cover property (rsp_valid_o && rsp_nak_o);

endmodule

`default_nettype wire

// ==== design/irm_pkg.sv ====
package irm_pkg;

   // --------------------------------------------------------------------
   // timing
   // --------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;                  // system clock period
   localparam int QUARTER_NS    = 2500;                // quarter of a 100 kHz bus bit
   localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // --------------------------------------------------------------------
   // bus encodings and field positions
   // --------------------------------------------------------------------
   localparam logic       RW_WRITE     = 1'b0;        // direction bit, write
   localparam logic       RW_READ      = 1'b1;        // direction bit, read
   localparam logic [3:0] ACK_SLOT     = 4'h8;        // bit index of the ack slot
   localparam logic [1:0] Q_DRIVE      = 2'h0;        // quarter: scl low, set sda
   localparam logic [1:0] Q_RISE       = 2'h1;        // quarter: scl released
   localparam logic [1:0] Q_SAMPLE     = 2'h2;        // quarter: sample sda
   localparam logic [1:0] Q_FALL       = 2'h3;        // quarter: scl pulled low
   localparam logic       PD_N_RESET   = 1'b0;        // power-down line after reset

   // --------------------------------------------------------------------
   // user commands and sequencer states
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_ADDR_WR,                                      // start + address, write
      OP_WRITE,                                        // one data byte out
      OP_RSTART_RD,                                    // repeated start + address, read
      OP_READ                                          // one data byte in
   } irm_op_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_RSTART,
      ST_BIT,
      ST_STOP
   } irm_state_t;

endpackage

// ==== design/irm_tick.sv ====
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------------
// quarter-bit enable divider
// ------------------------------------------------------------------------
module irm_tick #(
   parameter int DIV = 250                             // clock cycles per tick
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic run_i,                            // low holds the phase at zero
   output logic      tick_o                            // one-cycle enable pulse
);

   logic [15:0] cnt_reg;                               // cycle counter
   logic [15:0] cnt_next;

   // restart on idle so a transfer always begins with a full quarter
   always_comb begin
      if (!run_i || cnt_reg == 16'(DIV - 1)) begin
         cnt_next = 16'h0000;
      end else begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick_o = run_i && (cnt_reg == 16'(DIV - 1));

endmodule

`default_nettype wire

// ==== verification/irm_master_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module irm_master_tb
   import irm_pkg::*;
;
   // ------------------------------------------------------------------
   // table row: command, target behaviour and expected answer
   // ------------------------------------------------------------------
   typedef struct {
      irm_op_t    op;
      logic [6:0] addr;
      logic [7:0] data;
      logic       fin;                               // last byte of transfer
      logic       tnak;                              // target refuses data
      logic       nak;                               // expected nak answer
      logic [7:0] rdata;                             // expected read byte
      logic [7:0] abyte;                             // expected wire address byte
      logic       busy;                              // master mode after answer
      logic       refd;                              // refused at once
   } irm_row_t;

   irm_row_t rows [17] = '{
      '{OP_ADDR_WR,7'h23,8'h00,1'b0,1'b0,1'b0,8'h00,8'h46,1'b1,1'b0},
      '{OP_WRITE,7'h00,8'h12,1'b0,1'b0,1'b0,8'h00,8'h46,1'b1,1'b0},
      '{OP_RSTART_RD,7'h23,8'h00,1'b0,1'b0,1'b0,8'h00,8'h47,1'b1,1'b0},
      '{OP_READ,7'h00,8'h00,1'b0,1'b0,1'b0,8'h21,8'h47,1'b1,1'b0},
      '{OP_READ,7'h00,8'h00,1'b0,1'b0,1'b0,8'h43,8'h47,1'b1,1'b0},
      '{OP_READ,7'h00,8'h00,1'b0,1'b0,1'b0,8'h65,8'h47,1'b1,1'b0},
      '{OP_READ,7'h00,8'h00,1'b1,1'b0,1'b0,8'h87,8'h47,1'b0,1'b0},
      '{OP_ADDR_WR,7'h23,8'h00,1'b0,1'b0,1'b0,8'h00,8'h46,1'b1,1'b0},
      '{OP_WRITE,7'h00,8'hA5,1'b1,1'b0,1'b0,8'h00,8'h46,1'b0,1'b0},
      '{OP_WRITE,7'h00,8'h5A,1'b0,1'b0,1'b1,8'h00,8'h46,1'b0,1'b1},
      '{OP_READ,7'h00,8'h00,1'b0,1'b0,1'b1,8'h00,8'h46,1'b0,1'b1},
      '{OP_RSTART_RD,7'h23,8'h00,1'b0,1'b0,1'b1,8'h00,8'h46,1'b0,1'b1},
      '{OP_ADDR_WR,7'h11,8'h00,1'b0,1'b0,1'b1,8'h00,8'h22,1'b0,1'b0},
      '{OP_ADDR_WR,7'h23,8'h00,1'b0,1'b0,1'b0,8'h00,8'h46,1'b1,1'b0},
      '{OP_WRITE,7'h00,8'h55,1'b0,1'b1,1'b1,8'h00,8'h46,1'b0,1'b0},
      '{OP_ADDR_WR,7'h23,8'h00,1'b0,1'b0,1'b0,8'h00,8'h46,1'b1,1'b0},
      '{OP_READ,7'h00,8'h00,1'b0,1'b0,1'b1,8'h00,8'h46,1'b1,1'b1}
   };

   logic       clk_i, reset_i, cmd_valid_i, final_byte_flag_i, pd_release_i, t_nak, t_pull;
   logic       cmd_ready_o, rsp_valid_o, rsp_nak_o, busy_o, pd_n_o;
   logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, scl_w, sda_w;
   irm_op_t    cmd_op_i;
   logic [6:0] tgt_addr_i;
   logic [7:0] cmd_data_i, rsp_data_o, t_abyte;
   int         n_fail, check_count, cyc;

   // open-drain wires: pull-ups win unless someone pulls low
   assign scl_w = scl_oe_n_o ? 1'b1 : scl_o;
   assign sda_w = (sda_oe_n_o ? 1'b1 : sda_o) & !t_pull;

   // short quarter keeps each byte near 150 cycles
   irm_master #(.QUARTER(4)) dut (.clk_i, .reset_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i,
      .tgt_addr_i, .cmd_data_i, .final_byte_flag_i, .rsp_valid_o, .rsp_data_o, .rsp_nak_o,
      .busy_o, .pd_release_i, .pd_n_o, .scl_i(scl_w), .scl_o, .scl_oe_n_o, .sda_i(sda_w),
      .sda_o, .sda_oe_n_o);

   irm_target_model tgt (.scl_i(scl_w), .sda_i(sda_w), .nak_i(t_nak), .pull_o(t_pull),
      .addr_byte_o(t_abyte));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // offer one command, drop it after the taking edge, wait for the answer
   task automatic do_cmd(input irm_row_t r);
      @(negedge clk_i);
      cmd_op_i = r.op;
      {tgt_addr_i, cmd_data_i, final_byte_flag_i, t_nak} = {r.addr, r.data, r.fin, r.tnak};
      cmd_valid_i = 1'b1;
      cyc = 0;
      // ready is looked at away from the edge, so the taking edge is never misread
      while (cmd_ready_o !== 1'b1 && cyc < 100) begin
         cyc++;
         @(negedge clk_i);
      end
      cyc = 0;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      while (rsp_valid_o !== 1'b1 && cyc < 5000) begin
         cyc++;
         @(negedge clk_i);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // a hang gives up after some 40000 cycles
   initial begin
      #400000;
      n_fail++;
      final_report();
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      {reset_i, cmd_valid_i, final_byte_flag_i, pd_release_i, t_nak} = 5'h10;
      cmd_op_i = OP_ADDR_WR;
      {tgt_addr_i, cmd_data_i} = 15'h0000;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i) reset_i = 1'b0;
      chk("pd_n_o", 8'h00, {7'h00, pd_n_o});
      chk("oe_n", 8'h03, {6'h00, sda_oe_n_o, scl_oe_n_o});
      $display("reset test done");
      // ordinary transfers, refusals and naks from the table
      foreach (rows[i]) begin
         do_cmd(rows[i]);
         chk("rsp_valid_o", 8'h01, {7'h00, rsp_valid_o});
         chk("rsp_nak_o", {7'h00, rows[i].nak}, {7'h00, rsp_nak_o});
         chk("busy_o", {7'h00, rows[i].busy}, {7'h00, busy_o});
         chk("addr_byte", rows[i].abyte, t_abyte);
         if (rows[i].op == OP_READ && !rows[i].nak) chk("rsp_data_o", rows[i].rdata, rsp_data_o);
         if (rows[i].refd) chk("refusal_cycles", 8'h01, {7'h00, cyc <= 1});
         if (!rows[i].busy) chk("idle_lines", 8'h03, {6'h00, scl_w, sda_w});
         $display("row %0d done", i);
      end
      // power-down line lifted on request
      @(negedge clk_i) pd_release_i = 1'b1;
      @(negedge clk_i) pd_release_i = 1'b0;
      @(negedge clk_i);
      chk("pd_n_o", 8'h01, {7'h00, pd_n_o});
      $display("power-down test done");
      // reset in mid-address byte, then a clean write
      @(negedge clk_i);
      cmd_op_i = OP_ADDR_WR;
      {cmd_valid_i, tgt_addr_i} = {1'b1, 7'h23};
      @(negedge clk_i) cmd_valid_i = 1'b0;
      repeat (40) @(negedge clk_i);
      chk("busy_o", 8'h01, {7'h00, busy_o});
      reset_i = 1'b1;
      @(negedge clk_i);
      chk("oe_n", 8'h03, {6'h00, sda_oe_n_o, scl_oe_n_o});
      chk("pd_n_o", 8'h00, {7'h00, pd_n_o});
      @(negedge clk_i) reset_i = 1'b0;
      do_cmd(rows[7]);
      chk("rsp_nak_o", 8'h00, {7'h00, rsp_nak_o});
      do_cmd(rows[8]);
      chk("busy_o", 8'h00, {7'h00, busy_o});
      $display("mid-run reset test done");
      final_report();
   end
endmodule

`default_nettype wire

// ==== verification/irm_target_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// behavioural bus target holding one 32-bit register
// ----------------------------------------------------------------------
module irm_target_model #(
   parameter logic [6:0]  ADDR    = 7'h23,           // bus address of the target
   parameter logic [31:0] REG_VAL = 32'h87654321     // value returned by reads
) (
   input  wire logic       scl_i,                    // resolved clock wire
   input  wire logic       sda_i,                    // resolved data wire
   input  wire logic       nak_i,                    // refuse written data bytes
   output logic            pull_o,                   // high = pulling sda low
   output logic [7:0]      addr_byte_o               // last address byte seen
);
   int         cnt;                                  // bit of the byte, 8 = ack slot
   logic       act;                                  // taking part in the transfer
   logic       addr_ph;                              // address byte in flight
   logic       rd;                                   // read direction
   logic       send;                                 // master asked for a byte
   logic [1:0] idx;                                  // register byte being sent
   logic [7:0] shreg;                                // incoming bits
   logic [7:0] tx;                                   // outgoing byte

   initial begin
      pull_o      = 1'b0;
      act         = 1'b0;
      addr_byte_o = 8'h00;
   end

   // start or repeated start: data falls while the clock is high
   always @(negedge sda_i) begin
      if (scl_i === 1'b1) begin
         act     = 1'b1;
         addr_ph = 1'b1;
         rd      = 1'b0;
         send    = 1'b0;
         cnt     = -1;
      end
   end

   // stop: line let go so the pull-up wins
   always @(posedge sda_i) begin
      if (scl_i === 1'b1) begin
         act    = 1'b0;
         pull_o = 1'b0;
      end
   end

   // sample data and the master's ack on the rising clock
   always @(posedge scl_i) begin
      if (act && cnt >= 0 && cnt < 8) begin
         shreg = {shreg[6:0], sda_i};
      end else if (act && cnt == 8 && addr_ph) begin
         addr_ph = 1'b0;
         send    = rd;
         idx     = 2'h0;
      end else if (act && cnt == 8 && rd) begin
         send = !sda_i;                              // a nak ends the burst
         idx  = idx + 2'h1;
      end
   end

   // change the data line only while the clock is low
   always @(negedge scl_i) begin
      if (act) begin
         cnt    = (cnt == 8) ? 0 : cnt + 1;
         pull_o = 1'b0;
         if (cnt == 8 && addr_ph) begin
            addr_byte_o = shreg;
            act         = (shreg[7:1] == ADDR);
            rd          = shreg[0];
            pull_o      = act;
         end else if (cnt == 8 && !rd) begin
            pull_o = !nak_i;
         end else if (rd && send && cnt < 8) begin
            if (cnt == 0) begin
               tx = REG_VAL[8*idx +: 8];
            end
            pull_o = !tx[7 - cnt];
         end
      end
   end
endmodule

`default_nettype wire
